// File: rtl/ohc_pkg.sv
// overhead capture: shared constants, types and enumerations
// assumes one core clock domain and one serial link clock domain
package ohc_pkg;

  // ==========================================================
  // data path and memory layout
  localparam int DATA_W          = 8;
  localparam int WORD_BYTES      = 4;
  localparam int RAM_DEPTH_STM1  = 944;
  localparam int RAM_DEPTH_STM0  = 256;
  localparam int SEG1_BASE_STM1  = 512;
  localparam int SEG1_BASE_STM0  = 128;
  localparam int SEG_USED        = 432;
  localparam int RAM_AW          = 10;

  // ==========================================================
  // field and slot numbering
  localparam logic [4:0] FLD_A1       = 5'h00;
  localparam logic [4:0] FLD_A2       = 5'h01;
  localparam logic [4:0] FLD_M1       = 5'h18;
  localparam logic [4:0] FLD_M0       = 5'h19;
  localparam logic [4:0] FLD_LAST     = 5'h1a;
  localparam logic [1:0] GRP_UNUSED   = 2'h3;
  localparam logic [3:0] SLOT_THIRD   = 4'h2;
  localparam int         SER_SLOTS    = 9;

  // ==========================================================
  // reset values and counts
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] BYTE_CNT_RST = 3'h0;
  localparam logic [2:0] BYTE_CNT_END = 3'h4;
  localparam logic [2:0] BYTE_RET_END = 3'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [4:0]  field;
    logic [3:0]  slot;
    logic [7:0]  data;
  } ohc_cap_s;

  typedef struct packed {
    logic        first;
    logic [7:0]  data;
  } ohc_byte_s;

  typedef enum logic [1:0] {
    OHC_IDLE = 2'b00,
    OHC_READ = 2'b01,
    OHC_DONE = 2'b11
  } ohc_rd_e;

endpackage

// File: rtl/ohc_serializer.sv
// overhead capture: serial overhead output on the link clock
// assumes the byte handed over stays stable until the next request
`timescale 1ns/1ps
`default_nettype none

module ohc_serializer (
  input  wire logic              oh_serial_clock,
  input  wire logic              rst_n,
  input  wire logic              fetch_ack_tog,
  input  wire ohc_pkg::ohc_byte_s fetch_byte,
  output logic                   fetch_req_tog,
  output logic                   oh_serial_out,
  output logic                   oh_frame_marker,
  output logic                   oh_valid_flag,
  output logic                   path_oh_indicator
);

  logic              rst_s1;
  logic              rst_s2;
  logic              ack_s1;
  logic              ack_s2;
  logic              ack_s3;
  logic              have_next;
  logic              pending;
  ohc_pkg::ohc_byte_s next_byte;
  logic [7:0]        shreg;
  logic [2:0]        bit_cnt;
  logic              got;
  logic              load;

  // ==========================================================
  // reset release and ack crossing, all on the falling edge
  always_ff @(negedge oh_serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  always_ff @(negedge oh_serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end else begin
      ack_s1 <= fetch_ack_tog;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  assign got  = ack_s2 ^ ack_s3;
  assign load = (bit_cnt == 3'h0) && have_next;

  // ==========================================================
  // one byte of look-ahead, fetched by toggle handshake
  always_ff @(negedge oh_serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      have_next     <= 1'b0;
      pending       <= 1'b0;
      fetch_req_tog <= 1'b0;
      next_byte     <= '0;
    end else if (!rst_s2) begin
      have_next     <= 1'b0;
      pending       <= 1'b0;
    end else begin
      if (got) begin
        next_byte <= fetch_byte;
        have_next <= 1'b1;
        pending   <= 1'b0;
      end else if (load) begin
        have_next <= 1'b0;
      end
      if (!have_next && !pending && !got) begin
        fetch_req_tog <= ~fetch_req_tog;
        pending       <= 1'b1;
      end
    end
  end

  // ==========================================================
  // shifter; outputs only move on the falling edge
  always_ff @(negedge oh_serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      shreg           <= '0;
      bit_cnt         <= '0;
      oh_serial_out   <= 1'b0;
      oh_frame_marker <= 1'b0;
      oh_valid_flag   <= 1'b0;
    end else if (bit_cnt != 3'h0) begin
      shreg           <= {shreg[6:0], 1'b0};
      oh_serial_out   <= shreg[6];
      bit_cnt         <= bit_cnt - 3'h1;
      oh_frame_marker <= 1'b0;
    end else if (have_next) begin
      shreg           <= next_byte.data;
      oh_serial_out   <= next_byte.data[7];
      oh_frame_marker <= next_byte.first;
      oh_valid_flag   <= 1'b1;
      bit_cnt         <= ohc_pkg::BIT_LAST;
    end else begin
      // underrun only before the first byte arrives
      oh_serial_out   <= 1'b0;
      oh_frame_marker <= 1'b0;
      oh_valid_flag   <= 1'b0;
    end
  end

  // section overhead only, so the path indicator never rises
  always_ff @(negedge oh_serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      path_oh_indicator <= 1'b0;
    end else begin
      path_oh_indicator <= 1'b0;
    end
  end

endmodule // ohc_serializer

`default_nettype wire

// File: rtl/ohc_capture.sv
// overhead capture: double-buffered byte store, word reads, serial feed
// assumes capture bytes and read requests come from core_clk logic
`timescale 1ns/1ps
`default_nettype none

module ohc_capture #(
  parameter bit STM1      = 1'b1,
  parameter int SER_SLOTS = ohc_pkg::SER_SLOTS
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire ohc_pkg::ohc_cap_s cap_in,
  input  wire logic              cpu_rd_req,
  input  wire logic [7:0]        cpu_word_addr,
  output logic [31:0]            cpu_rd_data,
  output logic                   cpu_rd_done,
  output logic                   capture_done_irq,
  output logic [7:0]             oh_par_data,
  output logic                   oh_par_strobe,
  input  wire logic              oh_serial_clock,
  output logic                   oh_serial_out,
  output logic                   oh_frame_marker,
  output logic                   oh_valid_flag,
  output logic                   path_oh_indicator
);

  // ==========================================================
  // memory geometry
  localparam int DEPTH = STM1 ? ohc_pkg::RAM_DEPTH_STM1
                              : ohc_pkg::RAM_DEPTH_STM0;
  localparam int SEG1  = STM1 ? ohc_pkg::SEG1_BASE_STM1
                              : ohc_pkg::SEG1_BASE_STM0;
  localparam logic [3:0] SLOT_END = 4'(SER_SLOTS - 1);

  // ==========================================================
  // declarations
  logic [ohc_pkg::DATA_W-1:0] ram [DEPTH];
  logic [ohc_pkg::DATA_W-1:0] ram_q;
  logic [ohc_pkg::RAM_AW-1:0] ram_addr;
  logic                       ram_we;
  logic                       cap_seg;
  logic                       cpu_go;
  logic                       cpu_go_d;
  logic                       ser_go;
  logic                       ser_go_d;
  ohc_pkg::ohc_rd_e           rd_state;
  logic [7:0]                 rd_addr;
  logic [2:0]                 issue_cnt;
  logic [2:0]                 ret_cnt;
  logic [23:0]                word;
  logic                       req_s1;
  logic                       req_s2;
  logic                       req_s3;
  logic                       ser_pend;
  logic [4:0]                 ser_fld;
  logic [3:0]                 ser_slot;
  logic                       first_d;
  logic                       ack_tog;
  logic                       fetch_req_tog;
  ohc_pkg::ohc_byte_s         hold;

  // ==========================================================
  // helpers
  // entry = segment base + field * stride + slot
  function automatic logic [ohc_pkg::RAM_AW-1:0] ram_index(
    input logic       seg,
    input logic [4:0] fld,
    input logic [3:0] slot
  );
    logic [ohc_pkg::RAM_AW-1:0] base;
    base = seg ? ohc_pkg::RAM_AW'(SEG1) : '0;
    if (STM1) begin
      ram_index = base + {1'b0, fld, slot};
    end else begin
      ram_index = base + {3'b0, fld, slot[1:0]};
    end
  endfunction

  function automatic logic addr_unused(input logic [7:0] a);
    addr_unused = a[7]
                | (a[6:2] > ohc_pkg::FLD_LAST)
                | (a[1:0] == ohc_pkg::GRP_UNUSED)
                | (!STM1 && (a[1:0] != 2'h0));
  endfunction

  // ==========================================================
  // single port arbitration: capture, then serial feed, then cpu
  // capture never waits, since bytes arrive once per write slot
  always_comb begin
    ram_we   = cap_in.valid;
    ram_addr = ram_index(cap_seg, cap_in.field, cap_in.slot);
    cpu_go   = 1'b0;
    ser_go   = 1'b0;
    if (!cap_in.valid) begin
      if (ser_pend) begin
        ser_go = 1'b1;
        if (ser_fld == ohc_pkg::FLD_M0) begin
          ram_addr = ram_index(~cap_seg, ohc_pkg::FLD_M1,
                               ohc_pkg::SLOT_THIRD);
        end else begin
          ram_addr = ram_index(~cap_seg, ser_fld, ser_slot);
        end
      end else if (rd_state == ohc_pkg::OHC_READ &&
                   !issue_cnt[2]) begin
        cpu_go   = 1'b1;
        ram_addr = ram_index(~cap_seg, rd_addr[6:2],
                             {rd_addr[1:0], issue_cnt[1:0]});
      end
    end
  end

  // ==========================================================
  // capture memory
  always_ff @(posedge core_clk) begin
    if (ram_we) begin
      ram[ram_addr] <= cap_in.data;
    end
    ram_q <= ram[ram_addr];
  end

  // ==========================================================
  // segment swap and completion interrupt
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_seg          <= 1'b0;
      capture_done_irq <= 1'b0;
    end else begin
      capture_done_irq <= cap_in.valid && cap_in.last;
      if (cap_in.valid && cap_in.last) begin
        // holding side now keeps this frame until next swap
        cap_seg <= ~cap_seg;
      end
    end
  end

  // ==========================================================
  // processor word read, four byte reads over the 8-bit path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_go_d <= 1'b0;
      ser_go_d <= 1'b0;
    end else begin
      cpu_go_d <= cpu_go;
      ser_go_d <= ser_go;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state    <= ohc_pkg::OHC_IDLE;
      rd_addr     <= '0;
      issue_cnt   <= ohc_pkg::BYTE_CNT_RST;
      ret_cnt     <= ohc_pkg::BYTE_CNT_RST;
      word        <= '0;
      cpu_rd_data <= '0;
      cpu_rd_done <= 1'b0;
    end else begin
      cpu_rd_done <= 1'b0;
      case (rd_state)
        ohc_pkg::OHC_IDLE: begin
          issue_cnt <= ohc_pkg::BYTE_CNT_RST;
          ret_cnt   <= ohc_pkg::BYTE_CNT_RST;
          if (cpu_rd_req) begin
            rd_addr <= cpu_word_addr;
            if (addr_unused(cpu_word_addr)) begin
              cpu_rd_data <= '0;
              cpu_rd_done <= 1'b1;
              rd_state    <= ohc_pkg::OHC_DONE;
            end else begin
              rd_state <= ohc_pkg::OHC_READ;
            end
          end
        end
        ohc_pkg::OHC_READ: begin
          if (cpu_go) begin
            issue_cnt <= issue_cnt + 3'h1;
          end
          if (cpu_go_d) begin
            word    <= {word[15:0], ram_q};
            ret_cnt <= ret_cnt + 3'h1;
            if (ret_cnt == ohc_pkg::BYTE_RET_END) begin
              cpu_rd_data <= {word, ram_q};
              cpu_rd_done <= 1'b1;
              rd_state    <= ohc_pkg::OHC_DONE;
            end
          end
        end
        ohc_pkg::OHC_DONE: begin
          rd_state <= ohc_pkg::OHC_IDLE;
        end
        default: begin
          rd_state <= ohc_pkg::OHC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // serial feed: request toggle crossing from the link side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= fetch_req_tog;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // a new request wins over the grant of the previous one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_pend <= 1'b0;
    end else if (req_s2 ^ req_s3) begin
      ser_pend <= 1'b1;
    end else if (ser_go) begin
      ser_pend <= 1'b0;
    end
  end

  // byte order: field by field, slots within each field
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_fld  <= ohc_pkg::FLD_A1;
      ser_slot <= '0;
      first_d  <= 1'b0;
    end else if (ser_go) begin
      first_d <= (ser_fld == ohc_pkg::FLD_A1) &&
                 (ser_slot == 4'h0);
      if (ser_slot == SLOT_END) begin
        ser_slot <= '0;
        if (ser_fld == ohc_pkg::FLD_LAST) begin
          ser_fld <= ohc_pkg::FLD_A1;
        end else begin
          ser_fld <= ser_fld + 5'h01;
        end
      end else begin
        ser_slot <= ser_slot + 4'h1;
      end
    end
  end

  // hold stays put until the link asks again
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold          <= '0;
      ack_tog       <= 1'b0;
      oh_par_data   <= '0;
      oh_par_strobe <= 1'b0;
    end else begin
      oh_par_strobe <= ser_go_d;
      if (ser_go_d) begin
        hold.data   <= ram_q;
        hold.first  <= first_d;
        ack_tog     <= ~ack_tog;
        oh_par_data <= ram_q;
      end
    end
  end

  // ==========================================================
  // link side
  ohc_serializer u_ser (
    .oh_serial_clock   (oh_serial_clock),
    .rst_n             (rst_n),
    .fetch_ack_tog     (ack_tog),
    .fetch_byte        (hold),
    .fetch_req_tog     (fetch_req_tog),
    .oh_serial_out     (oh_serial_out),
    .oh_frame_marker   (oh_frame_marker),
    .oh_valid_flag     (oh_valid_flag),
    .path_oh_indicator (path_oh_indicator)
  );

endmodule // ohc_capture

`default_nettype wire

// File: sim/ohc_capture_checker.sv
// checker: port-level properties of the overhead capture block
// assumes it is bound to every ohc_capture instance
`timescale 1ns/1ps
`default_nettype none
module ohc_capture_checker #(
  parameter bit STM1      = 1'b1,
  parameter int SER_SLOTS = ohc_pkg::SER_SLOTS
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire ohc_pkg::ohc_cap_s cap_in,
  input wire logic              cpu_rd_req,
  input wire logic [7:0]        cpu_word_addr,
  input wire logic [31:0]       cpu_rd_data,
  input wire logic              cpu_rd_done,
  input wire logic              capture_done_irq,
  input wire logic [7:0]        oh_par_data,
  input wire logic              oh_par_strobe,
  input wire logic              oh_serial_clock,
  input wire logic              oh_serial_out,
  input wire logic              oh_frame_marker,
  input wire logic              oh_valid_flag,
  input wire logic              path_oh_indicator
);
  // ==========================================================
  // helper state
  logic       busy;
  logic [2:0] lat;
  logic       taken;
  logic       mapped;
  assign taken  = cpu_rd_req && !busy;
  assign mapped = !cpu_word_addr[7] &&
                  (cpu_word_addr[6:2] <= ohc_pkg::FLD_LAST) &&
                  (cpu_word_addr[1:0] != ohc_pkg::GRP_UNUSED) &&
                  (STM1 || cpu_word_addr[1:0] == 2'h0);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busy <= 1'b0;
    else if (cpu_rd_done) busy <= 1'b0;
    else if (cpu_rd_req) busy <= 1'b1;
  end
  // high phase snapshot; a change before the fall is a fault
  always_ff @(posedge oh_serial_clock or negedge rst_n) begin
    if (!rst_n) lat <= 3'h0;
    else lat <= {oh_serial_out, oh_frame_marker, oh_valid_flag};
  end
  // ==========================================================
  // core domain
  AST_IRQ_AFTER_LAST: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cap_in.valid && cap_in.last |=> capture_done_irq)
    else $error("irq missing after last byte");
  AST_IRQ_CAUSE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    capture_done_irq |-> $past(cap_in.valid && cap_in.last))
    else $error("irq without last byte");
  AST_UNUSED_ZERO: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    taken && !mapped |=> cpu_rd_done && cpu_rd_data == 32'h0)
    else $error("unused word not zero in one cycle");
  AST_MAPPED_MIN: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    taken && mapped |=> !cpu_rd_done [*5])
    else $error("mapped read done too early");
  AST_RD_BOUND: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    taken |-> ##[1:300] cpu_rd_done)
    else $error("read never completed");
  AST_DONE_PULSE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cpu_rd_done |=> !cpu_rd_done)
    else $error("done longer than one cycle");
  AST_DATA_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !cpu_rd_done |-> $stable(cpu_rd_data))
    else $error("read data moved without done");
  AST_PAR_PULSE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    oh_par_strobe |=> !oh_par_strobe)
    else $error("parallel strobe too long");
  // ==========================================================
  // link domain
  AST_POH_LOW: assert property (
    @(posedge oh_serial_clock) disable iff (!rst_n)
    path_oh_indicator == 1'b0)
    else $error("path indicator high");
  AST_FALL_ONLY: assert property (
    @(negedge oh_serial_clock) disable iff (!rst_n)
    {oh_serial_out, oh_frame_marker, oh_valid_flag} == lat)
    else $error("link output moved on rising edge");
  AST_MARKER_ONE: assert property (
    @(posedge oh_serial_clock) disable iff (!rst_n)
    oh_frame_marker |-> oh_valid_flag ##1 !oh_frame_marker)
    else $error("frame marker malformed");
  AST_VALID_KEEP: assert property (
    @(posedge oh_serial_clock) disable iff (!rst_n)
    oh_valid_flag |=> oh_valid_flag)
    else $error("valid dropped while running");
  COV_IRQ: cover property (@(posedge core_clk) capture_done_irq);
  COV_UNUSED: cover property (@(posedge core_clk) taken && !mapped);
  COV_MARK: cover property (@(posedge oh_serial_clock) oh_frame_marker);
endmodule // ohc_capture_checker
bind ohc_capture ohc_capture_checker #(.STM1(STM1), .SER_SLOTS(SER_SLOTS))
  chk (.core_clk(core_clk), .rst_n(rst_n), .cap_in(cap_in),
  .cpu_rd_req(cpu_rd_req), .cpu_word_addr(cpu_word_addr),
  .cpu_rd_data(cpu_rd_data), .cpu_rd_done(cpu_rd_done),
  .capture_done_irq(capture_done_irq), .oh_par_data(oh_par_data),
  .oh_par_strobe(oh_par_strobe), .oh_serial_clock(oh_serial_clock),
  .oh_serial_out(oh_serial_out), .oh_frame_marker(oh_frame_marker),
  .oh_valid_flag(oh_valid_flag), .path_oh_indicator(path_oh_indicator));
`default_nettype wire

// File: sim/ohc_oh_receiver.sv
// partner: downstream overhead receiver, makes the link clock
// assumes device outputs change on the falling link edge
`timescale 1ns/1ps
`default_nettype none
module ohc_oh_receiver (
  input  wire logic rst_n,
  input  wire logic oh_serial_out,
  input  wire logic oh_frame_marker,
  input  wire logic oh_valid_flag,
  output logic      oh_serial_clock,
  output logic [7:0] rx_byte,
  output logic      rx_first,
  output int        rx_cnt
);
  logic [7:0] sh;
  logic [2:0] nbit;
  logic       seen;
  logic       pend;
  // odd offset keeps it unrelated to the core clock
  initial begin
    oh_serial_clock = 1'b0;
    #3.7;
    forever #6 oh_serial_clock = ~oh_serial_clock;
  end
  // sample mid-bit on the rise, away from the falling update
  always @(posedge oh_serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      {seen, pend, rx_first, nbit, rx_byte, sh} = '0;
      rx_cnt = 0;
    end else if (oh_valid_flag === 1'b1) begin
      if (oh_frame_marker === 1'b1) begin
        seen = 1'b1;
        nbit = 3'h0;
        pend = 1'b1;
      end
      sh = {sh[6:0], oh_serial_out};
      if (seen && nbit == 3'h7) begin
        rx_byte = sh;
        rx_first = pend;
        pend = 1'b0;
        rx_cnt++;
      end
      nbit++;
    end
  end
endmodule // ohc_oh_receiver
`default_nettype wire

// File: sim/tb.sv
// testbench: frame capture, word reads, unused reads, serial stream
// assumes ohc_capture at STM-1 and the overhead receiver partner
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  // signals
  logic              core_clk = 1'b0;
  logic              rst_n;
  ohc_pkg::ohc_cap_s cap_in;
  logic              cpu_rd_req;
  logic [7:0]        cpu_word_addr;
  logic [31:0]       cpu_rd_data;
  logic              cpu_rd_done;
  logic              capture_done_irq;
  logic              oh_serial_clock;
  logic              oh_serial_out;
  logic              oh_frame_marker;
  logic              oh_valid_flag;
  logic              path_oh_indicator;
  logic [7:0]        oh_par_data;
  logic              oh_par_strobe;
  logic [7:0]        rx_byte;
  logic              rx_first;
  int                rx_cnt;
  logic [7:0]        img [27][12];
  logic [7:0]        nxt [27][12];
  logic [31:0]       rd_q [$];
  logic [7:0]        ser_q [$];
  logic [7:0]        par_q [$];
  int                irq_q = 0;
  int                n_fail = 0;
  int                compares = 0;
  logic [31:0]       lfsr = 32'hea597779;
  logic              armed = 1'b0;
  logic              started = 1'b0;
  localparam logic [7:0] UNUSED [6] =
    '{8'h03, 8'h07, 8'h6b, 8'h6c, 8'h7c, 8'h80};

  always #2 core_clk = ~core_clk;

  ohc_capture #(.STM1(1'b1), .SER_SLOTS(9)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .cap_in(cap_in),
    .cpu_rd_req(cpu_rd_req), .cpu_word_addr(cpu_word_addr),
    .cpu_rd_data(cpu_rd_data), .cpu_rd_done(cpu_rd_done),
    .capture_done_irq(capture_done_irq), .oh_par_data(oh_par_data),
    .oh_par_strobe(oh_par_strobe), .oh_serial_clock(oh_serial_clock),
    .oh_serial_out(oh_serial_out), .oh_frame_marker(oh_frame_marker),
    .oh_valid_flag(oh_valid_flag), .path_oh_indicator(path_oh_indicator));
  ohc_oh_receiver far (.rst_n(rst_n), .oh_serial_out(oh_serial_out),
    .oh_frame_marker(oh_frame_marker), .oh_valid_flag(oh_valid_flag),
    .oh_serial_clock(oh_serial_clock), .rx_byte(rx_byte),
    .rx_first(rx_first), .rx_cnt(rx_cnt));

  // ==========================================================
  // helpers
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [31:0] word(int f, int g);
    return {img[f][4*g], img[f][4*g+1], img[f][4*g+2], img[f][4*g+3]};
  endfunction
  task automatic bad(string m);
    n_fail++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk_word(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e) bad($sformatf("word %h expected %h", g, e));
  endtask
  task automatic chk_byte(logic [7:0] g, logic [7:0] e);
    compares++;
    if (g !== e) bad($sformatf("byte %h expected %h", g, e));
  endtask
  task automatic chk_bit(logic g, logic e);
    compares++;
    if (g !== e) bad($sformatf("flag %b expected %b", g, e));
  endtask
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_empty(int lim);
    int k;
    k = 0;
    while (rd_q.size() + ser_q.size() + par_q.size() + irq_q != 0 &&
           k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if (k == lim) begin
      bad("wait ran out");
      stop_test();
    end
  endtask
  // slots 0..11 so every group word is defined
  task automatic cap(int f0, int f1, bit fin);
    for (int f = f0; f <= f1; f++)
      for (int s = 0; s < 12; s++) begin
        @(posedge core_clk) #1;
        nxt[f][s] = rnd();
        cap_in = '{1'b1, fin && f == 26 && s == 11, f[4:0], s[3:0],
                   nxt[f][s]};
        if (cap_in.last) irq_q++;
        // one idle cycle per byte, as at line rate, keeps the link fed
        @(posedge core_clk) #1;
        cap_in.valid = 1'b0;
      end
    if (fin) img = nxt;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    rd_q.push_back(e);
    @(posedge core_clk) #1;
    cpu_word_addr = a;
    cpu_rd_req = 1'b1;
    @(posedge core_clk) #1;
    cpu_rd_req = 1'b0;
    wait_empty(300);
  endtask

  // ==========================================================
  // monitors
  always @(negedge core_clk) begin
    if (cpu_rd_done === 1'b1) begin
      if (rd_q.size() == 0) bad("read done not requested");
      else chk_word(cpu_rd_data, rd_q.pop_front());
    end
    if (capture_done_irq === 1'b1) begin
      chk_bit(irq_q > 0, 1'b1);
      if (irq_q > 0) irq_q--;
    end
    if (oh_par_strobe === 1'b1 && started && par_q.size() > 0)
      chk_byte(oh_par_data, par_q.pop_front());
  end
  always @(rx_cnt) begin
    if (armed && rx_first) started = 1'b1;
    if (started && ser_q.size() > 0)
      chk_byte(rx_byte, ser_q.pop_front());
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    cap_in = '0;
    cpu_rd_req = 1'b0;
    cpu_word_addr = 8'h00;
    // long enough for two link falls as well
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk_bit(capture_done_irq | cpu_rd_done | path_oh_indicator, 1'b0);
    $display("test reset done");
    cap(0, 26, 1);
    wait_empty(50);
    for (int f = 0; f < 27; f++)
      for (int g = 0; g < 3; g++)
        rd({1'b0, f[4:0], g[1:0]}, word(f, g));
    $display("test frame read done");
    for (int i = 0; i < 6; i++) rd(UNUSED[i], 32'h0);
    $display("test unused read done");
    cap(0, 9, 0);
    for (int f = 0; f < 10; f++) rd({1'b0, f[4:0], 2'h1}, word(f, 1));
    cap(10, 26, 1);
    wait_empty(50);
    for (int f = 0; f < 27; f++) rd({1'b0, f[4:0], 2'h0}, word(f, 0));
    fork
      cap(0, 5, 0);
      for (int f = 20; f < 27; f++) rd({1'b0, f[4:0], 2'h2}, word(f, 2));
    join
    $display("test swap done");
    for (int f = 0; f < 27; f++)
      for (int s = 0; s < 9; s++)
        ser_q.push_back(f == 25 ? img[24][2] : img[f][s]);
    // the byte after the first A1 is already fetched when the stream starts
    for (int i = 2; i < ser_q.size(); i++)
      par_q.push_back(ser_q[i]);
    armed = 1'b1;
    wait_empty(25000);
    $display("test serial done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
